/* File: rtl/uhsi_pkg.sv */
// shared constants for the host status and interrupt block
package uhsi_pkg;
    // register byte offsets
    localparam logic [7:0]  OFS_COMMAND   = 8'h00;
    localparam logic [7:0]  OFS_STATUS    = 8'h04;
    localparam logic [7:0]  OFS_ENABLE    = 8'h08;
    // status bit positions
    localparam int          STS_DONE      = 0;
    localparam int          STS_ERR       = 1;
    localparam int          STS_PORT      = 2;
    localparam int          STS_ROLL      = 3;
    localparam int          STS_SYSERR    = 4;
    localparam int          STS_ADV       = 5;
    localparam int          STS_HALTED    = 12;
    localparam int          STS_RECLAIM   = 13;
    localparam int          STS_PER       = 14;
    localparam int          STS_ASYNC     = 15;
    // command bit positions
    localparam int          CMD_RUN       = 0;
    localparam int          CMD_PER_EN    = 4;
    localparam int          CMD_ASYNC_EN  = 5;
    localparam int          CMD_DOORBELL  = 6;
    localparam int          CMD_THR_LSB   = 16;
    // reset values
    localparam logic [31:0] STATUS_RESET  = 32'h0000_1000;
    localparam logic [31:0] ENABLE_RESET  = 32'h0000_0000;
    localparam logic [7:0]  THR_RESET     = 8'h08;
    // flag groups: threshold-gated and immediate
    localparam logic [5:0]  THR_SOURCES   = 6'h23;
    localparam logic [5:0]  NOW_SOURCES   = 6'h1c;
    // one micro-frame is 125 us; at 40 MHz that is 5000 cycles
    localparam int          UFRAME_NS     = 125000;
    localparam int          CLK_NS        = 25;
    localparam int          UFRAME_CYCLES = UFRAME_NS / CLK_NS;
endpackage

/* File: rtl/uhsi_sync.sv */
// two-flop synchroniser for a bus of pin-level inputs
`timescale 1ns/1ps
module uhsi_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } uhsi_sync_type;

    uhsi_sync_type st_q;
    uhsi_sync_type st_d;

    always_comb begin
        st_d.s1 = din;
        st_d.s2 = st_q.s1;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign dout = st_q.s2;
endmodule

/* File: rtl/uhsi_thresh.sv */
// micro-frame tick and interrupt-threshold point generator
`timescale 1ns/1ps
module uhsi_thresh #(
    parameter int UFRAME_CYCLES = uhsi_pkg::UFRAME_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [7:0] thr_code,
    output logic            point
);
    typedef struct packed {
        logic [15:0] cyc;
        logic [7:0]  uf;
        logic        point;
    } uhsi_thr_type;

    uhsi_thr_type st_q;
    uhsi_thr_type st_d;

    // invalid codes act as one micro-frame rather than stalling forever
    function automatic logic [7:0] interval(input logic [7:0] c);
        case (c)
            8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40: interval = c;
            default: interval = 8'h01;
        endcase
    endfunction

    always_comb begin
        st_d = st_q;
        st_d.point = 1'b0;
        if (st_q.cyc == 16'(UFRAME_CYCLES - 1)) begin
            st_d.cyc = '0;
            if (st_q.uf + 8'h01 >= interval(thr_code)) begin // R19
                st_d.uf    = '0;
                st_d.point = 1'b1;
            end else begin
                st_d.uf = st_q.uf + 8'h01;
            end
        end else begin
            st_d.cyc = st_q.cyc + 16'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign point = st_q.point;
endmodule

/* File: rtl/uhsi_top.sv */
// status flags, interrupt enables and interrupt output of the host controller
// Behaviour
// (R1) write one clears a flag, zero keeps
// (R2) bit 15 tracks real async schedule state
// (R3) bit 14 tracks real periodic schedule state
// (R4) bit 13 read-only reclamation, resets zero
// (R5) halted zero while running, resets one
// (R6) halted set only after actual stop
// (R7) bit 5 latches on doorbell service
// (R8) bit 4 set on host memory error
// (R9) host error clears run control
// (R10) bit 3 set on frame index wrap
// (R11) bit 2 set on port change rise
// (R12) port flag reloaded on return to D0
// (R13) bit 1 on error, bit 0 if requested
// (R14) bit 0 on done-interrupt or short packet
// (R15) bits 5,1,0 interrupt at threshold points
// (R16) bits 4,3,2 interrupt immediately when enabled
// (R17) software acks by clearing status flag
// (R18) disabled sources still set flags
// (R19) threshold field picks 1..64 micro-frames
// (R20) doorbell self-clears after flag set
// (R21) interrupt is OR of gated sources
// (R22) reserved bits read zero, ignore writes
`timescale 1ns/1ps
module uhsi_top #(
    parameter int UFRAME_CYCLES = uhsi_pkg::UFRAME_CYCLES,
    parameter int PORTS         = 4
) (
    input  wire logic             CLK,
    input  wire logic             RST,
    // register port
    input  wire logic             REG_WR,
    input  wire logic             REG_RD,
    input  wire logic [7:0]       REG_ADDR,
    input  wire logic [31:0]      REG_WDATA,
    output logic      [31:0]      REG_RDATA,
    // controller-side events, same clock
    input  wire logic             TXN_DONE_IOC,
    input  wire logic             TXN_SHORT,
    input  wire logic             TXN_ERROR,
    input  wire logic             MEM_ERROR,
    input  wire logic             ASYNC_ADVANCED,
    input  wire logic [13:0]      FRAME_INDEX,
    input  wire logic             ASYNC_ACTIVE,
    input  wire logic             PERIODIC_ACTIVE,
    input  wire logic             RECLAIM,
    input  wire logic             ENGINE_STOPPED,
    input  wire logic             ENTER_D0,
    // port change, force-resume and owner bits from the port registers
    input  wire logic [PORTS-1:0] PORT_CHANGE,
    input  wire logic [PORTS-1:0] PORT_RESUME,
    input  wire logic [PORTS-1:0] PORT_OWNED,
    // controls seen by the schedule engines, and the interrupt output
    output logic                  RUN_CONTROL,
    output logic                  ASYNC_ENABLE,
    output logic                  PERIODIC_ENABLE,
    output logic                  DOORBELL,
    output logic                  IRQ
);
    typedef struct packed {
        logic [5:0]       flags;
        logic [5:0]       enable;
        logic             halted;
        logic             run;
        logic             async_en;
        logic             per_en;
        logic             doorbell;
        logic [7:0]       thr;
        logic             frame_msb;
        logic [PORTS-1:0] pchg;
        logic [PORTS-1:0] pres;
        logic [5:0]       thr_pend;
        logic [31:0]      rdata;
    } uhsi_state_type;

    uhsi_state_type   st_q;
    uhsi_state_type   st_d;
    logic [PORTS-1:0] port_chg_s;
    logic [PORTS-1:0] port_res_s;
    logic [PORTS-1:0] port_own_s;
    logic             thr_point;
    logic             wr_cmd;
    logic             wr_sts;
    logic             wr_en;
    logic [5:0]       set_ev;
    logic [31:0]      status_view;
    logic             port_any;
    logic [5:0]       w1c_mask;

    // ------------------------------------------------------------
    // port bits arrive from the suspend well, so synchronise them
    // ------------------------------------------------------------
    uhsi_sync #(.W(3 * PORTS)) u_port_sync (
        .clk  (CLK),
        .rst  (RST),
        .din  ({PORT_CHANGE, PORT_RESUME, PORT_OWNED}),
        .dout ({port_chg_s, port_res_s, port_own_s})
    );

    uhsi_thresh #(.UFRAME_CYCLES(UFRAME_CYCLES)) u_thresh (
        .clk      (CLK),
        .rst      (RST),
        .thr_code (st_q.thr),
        .point    (thr_point)
    );

    function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] ofs);
        addr_hit = (a == ofs);
    endfunction

    assign wr_cmd = REG_WR && addr_hit(REG_ADDR, uhsi_pkg::OFS_COMMAND);
    assign wr_sts = REG_WR && addr_hit(REG_ADDR, uhsi_pkg::OFS_STATUS);
    assign wr_en  = REG_WR && addr_hit(REG_ADDR, uhsi_pkg::OFS_ENABLE);

    // bits a status write really clears, and the live port summary for D0 reload
    assign w1c_mask = wr_sts ? (REG_WDATA[5:0] & ~set_ev) : 6'h00;
    assign port_any = |(port_own_s & (port_chg_s | port_res_s));

    // ------------------------------------------------------------
    // event detection
    // ------------------------------------------------------------
    always_comb begin
        set_ev = '0;
        set_ev[uhsi_pkg::STS_DONE]   = TXN_DONE_IOC || TXN_SHORT;                        // R14 R13
        set_ev[uhsi_pkg::STS_ERR]    = TXN_ERROR;                                        // R13
        set_ev[uhsi_pkg::STS_PORT]   = |(port_own_s & ((port_chg_s & ~st_q.pchg)
                                                       | (port_res_s & ~st_q.pres)));  // R11
        set_ev[uhsi_pkg::STS_ROLL]   = FRAME_INDEX[13] != st_q.frame_msb;                // R10
        set_ev[uhsi_pkg::STS_SYSERR] = MEM_ERROR;                                        // R8
        set_ev[uhsi_pkg::STS_ADV]    = ASYNC_ADVANCED && st_q.doorbell;                  // R7
    end

    // live status word; reserved bits stay zero
    always_comb begin
        status_view = '0;                                                                // R22
        status_view[5:0]                   = st_q.flags;
        status_view[uhsi_pkg::STS_HALTED]  = st_q.halted;                                // R5
        status_view[uhsi_pkg::STS_RECLAIM] = RECLAIM;                                    // R4
        status_view[uhsi_pkg::STS_PER]     = PERIODIC_ACTIVE;                            // R3
        status_view[uhsi_pkg::STS_ASYNC]   = ASYNC_ACTIVE;                               // R2
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        st_d.frame_msb = FRAME_INDEX[13];
        st_d.pchg      = port_chg_s;
        st_d.pres      = port_res_s;

        // flags: clear by writing one, set wins over clear
        if (wr_sts) begin
            st_d.flags = st_q.flags & ~REG_WDATA[5:0];                                   // R1
        end
        st_d.flags = st_d.flags | set_ev;                                                // R18
        // port flag rebuilt from live port bits on return to D0
        if (ENTER_D0) begin
            st_d.flags[uhsi_pkg::STS_PORT] = port_any;                                   // R12
        end

        if (wr_en) begin
            st_d.enable = REG_WDATA[5:0];                                                // R22
        end

        if (wr_cmd) begin
            st_d.run      = REG_WDATA[uhsi_pkg::CMD_RUN];
            st_d.async_en = REG_WDATA[uhsi_pkg::CMD_ASYNC_EN];
            st_d.per_en   = REG_WDATA[uhsi_pkg::CMD_PER_EN];
            st_d.thr      = REG_WDATA[uhsi_pkg::CMD_THR_LSB +: 8];                       // R19
            if (REG_WDATA[uhsi_pkg::CMD_DOORBELL]) begin
                st_d.doorbell = 1'b1;
            end
        end
        // doorbell drops once its status flag is latched
        if (set_ev[uhsi_pkg::STS_ADV]) begin
            st_d.doorbell = 1'b0;                                                        // R20
        end
        // host error stops the schedule, overriding any write
        if (MEM_ERROR) begin
            st_d.run = 1'b0;                                                             // R9
        end

        if (st_d.run) begin
            st_d.halted = 1'b0;                                                          // R5
        end else if (!st_q.run && ENGINE_STOPPED) begin
            st_d.halted = 1'b1;                                                          // R6
        end

        // threshold sources become visible only at a threshold point
        if (thr_point) begin
            // a flag cleared on the point edge must not reach the snapshot
            st_d.thr_pend = st_q.flags & st_d.flags & uhsi_pkg::THR_SOURCES;             // R15
        end else begin
            st_d.thr_pend = st_q.thr_pend & st_d.flags;                                  // R17
        end

        st_d.rdata = '0;
        if (REG_RD) begin
            case (REG_ADDR)
                uhsi_pkg::OFS_COMMAND: begin
                    st_d.rdata[uhsi_pkg::CMD_RUN]          = st_q.run;
                    st_d.rdata[uhsi_pkg::CMD_PER_EN]       = st_q.per_en;
                    st_d.rdata[uhsi_pkg::CMD_ASYNC_EN]     = st_q.async_en;
                    st_d.rdata[uhsi_pkg::CMD_DOORBELL]     = st_q.doorbell;
                    st_d.rdata[uhsi_pkg::CMD_THR_LSB +: 8] = st_q.thr;
                end
                uhsi_pkg::OFS_STATUS: st_d.rdata = status_view;
                uhsi_pkg::OFS_ENABLE: st_d.rdata[5:0] = st_q.enable;                     // R22
                default:              st_d.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            st_q          <= '0;
            st_q.halted   <= uhsi_pkg::STATUS_RESET[uhsi_pkg::STS_HALTED];               // R5
            st_q.thr      <= uhsi_pkg::THR_RESET;
            st_q.enable   <= uhsi_pkg::ENABLE_RESET[5:0];
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // immediate sources use live flags; gated ones wait for a point
    assign IRQ = |(st_q.enable & ((st_q.flags & uhsi_pkg::NOW_SOURCES)                   // R16
                                  | st_q.thr_pend));                                     // R21
    assign REG_RDATA       = st_q.rdata;
    assign RUN_CONTROL     = st_q.run;
    assign ASYNC_ENABLE    = st_q.async_en;
    assign PERIODIC_ENABLE = st_q.per_en;
    assign DOORBELL        = st_q.doorbell;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_mem_err;
        MEM_ERROR;
    endsequence

    sequence s_stopped;
        !RUN_CONTROL;
    endsequence

    sequence s_sts_rd;
        REG_RD && REG_ADDR == uhsi_pkg::OFS_STATUS;
    endsequence

    sequence s_en_rd;
        REG_RD && REG_ADDR == uhsi_pkg::OFS_ENABLE;
    endsequence

    AST_W1C_KEEP: assert property (@(posedge CLK) disable iff (RST) // R1
        wr_sts && REG_WDATA[1:0] == 2'b00 && (st_q.flags[1:0] == 2'b11) |=> st_q.flags[1:0] == 2'b11)
        else $error("flag lost on zero write");
    AST_HALT_RUN: assert property (@(posedge CLK) disable iff (RST) // R5
        RUN_CONTROL |-> !st_q.halted)
        else $error("halted while running");
    AST_HALT_CAUSE: assert property (@(posedge CLK) disable iff (RST) // R6
        $rose(st_q.halted) |-> $past(ENGINE_STOPPED) && !$past(st_q.run))
        else $error("halted set without stop");
    AST_ADV_SET: assert property (@(posedge CLK) disable iff (RST) // R7
        ASYNC_ADVANCED && DOORBELL |=> st_q.flags[uhsi_pkg::STS_ADV] && !DOORBELL)
        else $error("advance flag or doorbell wrong");
    AST_SYSERR: assert property (@(posedge CLK) disable iff (RST) // R9
        s_mem_err |=> s_stopped ##0 st_q.flags[uhsi_pkg::STS_SYSERR])
        else $error("host error did not stop run");
    AST_ROLL: assert property (@(posedge CLK) disable iff (RST) // R10
        FRAME_INDEX[13] != st_q.frame_msb |=> st_q.flags[uhsi_pkg::STS_ROLL])
        else $error("rollover not flagged");
    AST_ERR_DONE: assert property (@(posedge CLK) disable iff (RST) // R13
        TXN_ERROR && TXN_DONE_IOC |=> st_q.flags[1:0] == 2'b11)
        else $error("error with completion not both set");
    AST_THR_GATE: assert property (@(posedge CLK) disable iff (RST) // R15
        (st_q.enable & uhsi_pkg::NOW_SOURCES) == 6'h00 && st_q.thr_pend == 6'h00 |-> !IRQ)
        else $error("gated interrupt before threshold");
    AST_NOW_IRQ: assert property (@(posedge CLK) disable iff (RST) // R16
        st_q.enable[uhsi_pkg::STS_SYSERR] && st_q.flags[uhsi_pkg::STS_SYSERR] |-> IRQ)
        else $error("immediate source not raised");

    // ------------------------------------------------------------
    // rule checks
    // ------------------------------------------------------------
    // clearing, run control and reset values
    AST_W1C_CLEAR: assert property (@(posedge CLK) disable iff (RST) // R1
        wr_sts |=> (st_q.flags & $past(w1c_mask) & 6'h3b) == 6'h00)
        else $error("flag survived a clearing write");
    AST_HALT_RESET: assert property (@(posedge CLK) // R5
        $fell(RST) |-> st_q.halted && !RUN_CONTROL && !IRQ)
        else $error("wrong state after reset");
    AST_RUN_HOLD: assert property (@(posedge CLK) disable iff (RST) // R9
        !RUN_CONTROL && !wr_cmd |=> !RUN_CONTROL)
        else $error("run set without a command write");

    // live schedule bits and reserved fields on read-back
    AST_ASYNC_LIVE: assert property (@(posedge CLK) disable iff (RST) // R2
        s_sts_rd |=> REG_RDATA[uhsi_pkg::STS_ASYNC] == $past(ASYNC_ACTIVE))
        else $error("async schedule bit wrong");
    AST_PER_LIVE: assert property (@(posedge CLK) disable iff (RST) // R3
        s_sts_rd |=> REG_RDATA[uhsi_pkg::STS_PER] == $past(PERIODIC_ACTIVE))
        else $error("periodic schedule bit wrong");
    AST_RECLAIM_LIVE: assert property (@(posedge CLK) disable iff (RST) // R4
        s_sts_rd |=> REG_RDATA[uhsi_pkg::STS_RECLAIM] == $past(RECLAIM))
        else $error("reclamation bit wrong");
    AST_RSV_STS: assert property (@(posedge CLK) disable iff (RST) // R22
        s_sts_rd |=> REG_RDATA[31:16] == 16'h0000 && REG_RDATA[11:6] == 6'h00)
        else $error("reserved status bits set");
    AST_RSV_EN: assert property (@(posedge CLK) disable iff (RST) // R22
        s_en_rd |=> REG_RDATA[31:6] == 26'h0000000)
        else $error("reserved enable bits set");

    // each flag sets on its own event; error, rollover, host error and advance flags set only on it
    AST_DONE_SET: assert property (@(posedge CLK) disable iff (RST) // R14
        TXN_DONE_IOC || TXN_SHORT |=> st_q.flags[uhsi_pkg::STS_DONE])
        else $error("done flag not set");
    AST_ERR_ONLY: assert property (@(posedge CLK) disable iff (RST) // R13
        !TXN_ERROR && !st_q.flags[uhsi_pkg::STS_ERR] |=> !st_q.flags[uhsi_pkg::STS_ERR])
        else $error("error flag set without error");
    AST_PORT_SET: assert property (@(posedge CLK) disable iff (RST) // R11
        |(port_own_s & port_chg_s & ~st_q.pchg) |=> st_q.flags[uhsi_pkg::STS_PORT])
        else $error("port change not flagged");
    AST_ROLL_ONLY: assert property (@(posedge CLK) disable iff (RST) // R10
        FRAME_INDEX[13] == st_q.frame_msb && !st_q.flags[uhsi_pkg::STS_ROLL] |=> !st_q.flags[uhsi_pkg::STS_ROLL])
        else $error("rollover flagged without wrap");
    AST_SYSERR_ONLY: assert property (@(posedge CLK) disable iff (RST) // R8
        !MEM_ERROR && !st_q.flags[uhsi_pkg::STS_SYSERR] |=> !st_q.flags[uhsi_pkg::STS_SYSERR])
        else $error("host error flagged without error");
    AST_ADV_ONLY: assert property (@(posedge CLK) disable iff (RST) // R7
        !(ASYNC_ADVANCED && DOORBELL) && !st_q.flags[uhsi_pkg::STS_ADV] |=> !st_q.flags[uhsi_pkg::STS_ADV])
        else $error("advance flagged without service");
    AST_D0_RELOAD: assert property (@(posedge CLK) disable iff (RST) // R12
        ENTER_D0 |=> st_q.flags[uhsi_pkg::STS_PORT] == $past(port_any))
        else $error("port flag not reloaded");
    AST_DISABLED_SET: assert property (@(posedge CLK) disable iff (RST) // R18
        st_q.enable == 6'h00 && TXN_ERROR |=> st_q.flags[uhsi_pkg::STS_ERR])
        else $error("disabled source did not flag");

    // interrupt gating and doorbell
    AST_THR_ONLY: assert property (@(posedge CLK) disable iff (RST) // R15
        !thr_point |=> (st_q.thr_pend & ~$past(st_q.thr_pend)) == 6'h00)
        else $error("gated source pending off a threshold point");
    AST_IRQ_ACK: assert property (@(posedge CLK) disable iff (RST) // R21
        IRQ |-> (st_q.enable & st_q.flags) != 6'h00)
        else $error("interrupt without an enabled flag");
    AST_DOORBELL_HOLD: assert property (@(posedge CLK) disable iff (RST) // R20
        DOORBELL && !ASYNC_ADVANCED |=> DOORBELL)
        else $error("doorbell dropped before service");
endmodule

/* File: verif/usb_host_status_interrupt_tb.sv */
// self-checking bench for the host status and interrupt block
`timescale 1ns/1ps
module usb_host_status_interrupt_tb;
    localparam int UF = 10;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic [31:0] reg_rdata;
    logic [4:0]  evt = 5'h00;
    logic [13:0] frame_index = 14'h0000;
    logic [2:0]  live = 3'h0;
    logic        engine_stopped = 1'b1;
    logic        enter_d0 = 1'b0;
    logic [3:0]  port_change = 4'h0;
    logic [3:0]  port_resume = 4'h0;
    logic [3:0]  port_owned = 4'h5;
    logic        run_control, async_enable, periodic_enable, doorbell, irq;
    logic [31:0] m_flags, rv, rb;
    logic        m_halt;
    int          mismatches = 0;
    int          checks_done = 0;
    int          seed = 82;
    int          cyc = 0;
    int          n;
    int          map [4] = '{0, 0, 1, 4};

    uhsi_top #(.UFRAME_CYCLES(UF), .PORTS(4)) uut (
        .CLK(clk), .RST(rst), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .TXN_DONE_IOC(evt[0]), .TXN_SHORT(evt[1]),
        .TXN_ERROR(evt[2]), .MEM_ERROR(evt[3]), .ASYNC_ADVANCED(evt[4]), .FRAME_INDEX(frame_index),
        .ASYNC_ACTIVE(live[2]), .PERIODIC_ACTIVE(live[1]), .RECLAIM(live[0]),
        .ENGINE_STOPPED(engine_stopped), .ENTER_D0(enter_d0), .PORT_CHANGE(port_change),
        .PORT_RESUME(port_resume), .PORT_OWNED(port_owned), .RUN_CONTROL(run_control),
        .ASYNC_ENABLE(async_enable), .PERIODIC_ENABLE(periodic_enable), .DOORBELL(doorbell), .IRQ(irq));

    always #12.5 clk = ~clk;

    // hang guard, far above the longest threshold wait
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            mismatches = mismatches + 1;
            print_verdict();
        end
    end

    task automatic print_verdict();
        if (mismatches == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // the bus and event tasks start and end on a falling edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'b0;
        @(negedge clk);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge clk);
        reg_rd = 1'b0;
        d = reg_rdata;
        @(negedge clk);
    endtask

    function automatic logic [31:0] exp_sts();
        return m_flags | {16'h0000, live, m_halt, 12'h000};
    endfunction

    task automatic sts();
        rd(uhsi_pkg::OFS_STATUS, rv);
        chk("status", rv, exp_sts());
    endtask

    task automatic ev(input logic [4:0] m);
        evt = m;
        @(negedge clk);
        evt = 5'h00;
        @(negedge clk);
    endtask

    task automatic clr(input logic [31:0] m);
        wr(uhsi_pkg::OFS_STATUS, m);
        m_flags = m_flags & ~(m & 32'h3f);
    endtask

    initial begin
        m_flags = 32'h0;
        m_halt = 1'b1;
        repeat (6) @(negedge clk);
        rst = 1'b0;
        sts();
        rd(uhsi_pkg::OFS_ENABLE, rv);
        chk("enable reset", rv, uhsi_pkg::ENABLE_RESET);
        chk("irq reset", {31'h0, irq}, 32'h0);
        for (int i = 0; i < 4; i++) begin
            rv = $random(seed);
            wr(uhsi_pkg::OFS_ENABLE, rv);
            rd(uhsi_pkg::OFS_ENABLE, rb);
            chk("enable", rb, rv & 32'h3f);
            live = $random(seed);
            sts();
        end
        wr(uhsi_pkg::OFS_ENABLE, 32'h0);
        wr(8'h3c, 32'hffff_ffff);
        rd(8'h3c, rv);
        chk("unmapped", rv, 32'h0);
        // done, short, error and host error sources still flag while disabled
        for (int k = 0; k < 4; k++) begin
            ev(5'h01 << k);
            m_flags[map[k]] = 1'b1;
            sts();
            rv = $random(seed);
            clr(rv);
            sts();
            clr(32'hffff_ffff);
        end
        ev(5'h05);
        m_flags[1:0] = 2'h3;
        sts();
        frame_index = 14'h0ff7;
        repeat (2) @(negedge clk);
        sts();
        frame_index = 14'h2000;
        m_flags[3] = 1'b1;
        repeat (2) @(negedge clk);
        sts();
        clr(32'h3f);
        // run clears halted even while the engine is idle
        wr(uhsi_pkg::OFS_COMMAND, 32'h0008_0001);
        m_halt = 1'b0;
        chk("run", {31'h0, run_control}, 32'h1);
        sts();
        engine_stopped = 1'b0;
        ev(5'h08);
        m_flags[4] = 1'b1;
        chk("run after mem err", {31'h0, run_control}, 32'h0);
        sts();
        engine_stopped = 1'b1;
        repeat (2) @(negedge clk);
        m_halt = 1'b1;
        sts();
        clr(32'h10);
        // doorbell service
        wr(uhsi_pkg::OFS_COMMAND, 32'h0008_0070);
        chk("doorbell", {29'h0, periodic_enable, async_enable, doorbell}, 32'h7);
        ev(5'h10);
        m_flags[5] = 1'b1;
        chk("doorbell clear", {31'h0, doorbell}, 32'h0);
        sts();
        clr(32'h20);
        // immediate source through the port synchroniser
        wr(uhsi_pkg::OFS_ENABLE, 32'h04);
        port_change = 4'h2;
        repeat (6) @(negedge clk);
        sts();
        chk("irq unowned", {31'h0, irq}, 32'h0);
        port_change = 4'h3;
        repeat (6) @(negedge clk);
        m_flags[2] = 1'b1;
        sts();
        chk("irq port", {31'h0, irq}, 32'h1);
        clr(32'h04);
        chk("irq cleared", {31'h0, irq}, 32'h0);
        sts();
        enter_d0 = 1'b1;
        @(negedge clk);
        enter_d0 = 1'b0;
        @(negedge clk);
        m_flags[2] = 1'b1;
        sts();
        clr(32'h04);
        // force-resume rise on an owned port flags as well
        port_resume = 4'h1;
        repeat (6) @(negedge clk);
        m_flags[2] = 1'b1;
        sts();
        port_change = 4'h0;
        port_resume = 4'h0;
        clr(32'h04);
        // gated source at each threshold code
        wr(uhsi_pkg::OFS_ENABLE, 32'h01);
        for (int t = 0; t < 7; t++) begin
            wr(uhsi_pkg::OFS_COMMAND, 32'h0001_0000 << t);
            ev(5'h02);
            n = 0;
            while (irq !== 1'b1 && n < 700) begin
                @(negedge clk);
                n++;
            end
            chk("irq gated", {31'h0, irq}, 32'h1);
            chk("irq late", {31'h0, (n <= (1 << t) * UF + 2)}, 32'h1);
            clr(32'h01);
            chk("irq ack", {31'h0, irq}, 32'h0);
        end
        // second reset with a flag pending and a non-default threshold loaded
        ev(5'h08);
        rst = 1'b1;
        frame_index = 14'h0000;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        m_flags = 32'h0;
        sts();
        rd(uhsi_pkg::OFS_COMMAND, rv);
        chk("command reset", rv, {8'h00, uhsi_pkg::THR_RESET, 16'h0000});
        chk("irq after reset", {31'h0, irq}, 32'h0);
        print_verdict();
    end
endmodule
